// >>> rtl/secm_bucket.v
`timescale 1ns/1ps
// ----------------------------------------
// Leaky bucket soft error burst detector
// ----------------------------------------
module secm_bucket #(
  parameter W = 4,
  parameter [3:0] ADD = 4'h4,
  parameter [3:0] LIMIT = 4'hc,
  parameter [7:0] LEAK = 8'h40
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Event in, burst out
  input wire soft_in,
  output reg burst
);
  reg [W:0] fill_reg;
  reg [7:0] leak_reg;
  wire leak_tick;
  wire [W:0] sum;

  assign leak_tick = (leak_reg == LEAK - 8'h01);
  assign sum = fill_reg + {1'b0, ADD};

  // Each soft error adds while fill is at or under the limit; fill drains by one per leak period on an error-free tick
  always @(posedge clk) begin
    if (rst) begin
      fill_reg <= {(W+1){1'b0}};
      leak_reg <= 8'h00;
      burst <= 1'b0;
    end else begin
      leak_reg <= leak_tick ? 8'h00 : leak_reg + 8'h01;
      // Fill stops once over the limit so a long burst cannot wrap it to empty
      if (soft_in) begin
        if (fill_reg <= {1'b0, LIMIT}) begin
          fill_reg <= sum;
        end
      end else if (leak_tick && fill_reg != {(W+1){1'b0}}) begin
        fill_reg <= fill_reg - {{W{1'b0}}, 1'b1};
      end
      // One isolated error never reaches the limit
      burst <= soft_in && (sum > {1'b0, LIMIT});
    end
  end
endmodule

// >>> rtl/secm_defs.vh
`ifndef SECM_DEFS_VH
`define SECM_DEFS_VH

// ----------------------------------------
// Leaky bucket for soft errors
// ----------------------------------------
`define SECM_BUCKET_W 4
`define SECM_BUCKET_ADD 4'h4
`define SECM_BUCKET_LIMIT 4'hc
`define SECM_LEAK_PERIOD 8'h40

// ----------------------------------------
// Recovery timing and lane count
// ----------------------------------------
`define SECM_RESET_HOLD_CYCLES 4'h8
`define SECM_LANES 4

`endif

// >>> rtl/secm_top.v
`timescale 1ns/1ps
`include "secm_defs.vh"

module secm_top #(
  parameter LANES = `SECM_LANES,
  parameter SIMPLEX = 0,
  parameter TX_ONLY = 0,
  parameter DW = 16
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Per-lane receive symbol status
  input wire [LANES-1:0] rx_code_invalid,
  input wire [LANES-1:0] rx_disp_err,
  // Per-lane buffer and lock status
  input wire [LANES-1:0] tx_buf_err,
  input wire [LANES-1:0] rx_buf_err,
  input wire [LANES-1:0] lock_lost,
  // Protocol engine events
  input wire tx_bad_ctrl,
  input wire rx_unknown_ctrl,
  input wire rx_sof,
  input wire rx_eof,
  input wire rx_data_beat,
  input wire ufc_len_bad,
  // Lane init progress from lane engines
  input wire [LANES-1:0] lane_init_done,
  input wire bond_done,
  // Receive data path
  input wire [DW-1:0] rx_data_in,
  input wire rx_valid_in,
  // Status outputs
  output reg soft_err,
  output reg hard_err,
  output reg rx_hard_err,
  output reg frame_err,
  output reg [LANES-1:0] lane_up,
  output reg channel_up,
  output reg init_restart,
  // Delivered receive data
  output reg [DW-1:0] rx_data_out,
  output reg rx_valid_out
);

  // ----------------------------------------
  // Error classification
  // ----------------------------------------
  localparam ST_RESET = 3'b001;
  localparam ST_INIT = 3'b010;
  localparam ST_UP = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [3:0] hold_reg;
  reg frame_open_reg;
  wire soft_now;
  wire burst;
  wire tx_hard;
  wire rx_hard;
  wire any_hard;
  wire frame_now;
  wire all_lanes;
  reg frame_has_data_reg;

  // Receive symbol faults, any lane, counted per cycle
  assign soft_now = (TX_ONLY == 0) && ((|rx_code_invalid) || (|rx_disp_err));

  // Soft bursts only reach hard error through the bucket
  secm_bucket #(
    .W(`SECM_BUCKET_W),
    .ADD(`SECM_BUCKET_ADD),
    .LIMIT(`SECM_BUCKET_LIMIT),
    .LEAK(`SECM_LEAK_PERIOD)
  ) u_bucket (
    .clk(clk),
    .rst(rst),
    .soft_in(soft_now),
    .burst(burst)
  );

  assign tx_hard = (TX_ONLY != 0 || SIMPLEX == 0) && ((|tx_buf_err) || tx_bad_ctrl);
  assign rx_hard = (TX_ONLY == 0) && ((|rx_buf_err) || burst);
  assign any_hard = tx_hard || rx_hard || (|lock_lost);

  // Empty frame, nested start, orphan end, bad control, bad flow length
  assign frame_now = (TX_ONLY == 0) && (
    (rx_eof && frame_open_reg && !frame_has_data_reg && !rx_data_beat && !rx_sof)
    || (rx_sof && rx_eof && !frame_open_reg && !rx_data_beat)
    || (rx_sof && frame_open_reg)
    || (rx_eof && !frame_open_reg && !rx_sof)
    || rx_unknown_ctrl
    || ufc_len_bad);

  // ----------------------------------------
  // Frame tracking
  // ----------------------------------------
  // Tracks open frame and whether any data arrived; single-beat frames
  // (start and end together) carrying data count as valid
  always @(posedge clk) begin
    if (rst || state_reg != ST_UP) begin
      frame_open_reg <= 1'b0;
      frame_has_data_reg <= 1'b0;
    end else if (rx_sof && !rx_eof) begin
      frame_open_reg <= 1'b1;
      frame_has_data_reg <= rx_data_beat;
    end else if (rx_eof) begin
      frame_open_reg <= 1'b0;
      frame_has_data_reg <= 1'b0;
    end else if (rx_data_beat) begin
      frame_has_data_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Initialization control
  // ----------------------------------------
  assign all_lanes = &lane_init_done;

  // Restart on any hard error from any state except reset hold
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET: begin
        // A hard error at the end of the hold keeps the restart going
        if (hold_reg == 4'h0 && !any_hard) begin
          state_next = ST_INIT;
        end
      end
      ST_INIT: begin
        if (any_hard) begin
          state_next = ST_RESET;
        end else if (all_lanes && (bond_done || LANES == 1)) begin
          state_next = ST_UP;
        end
      end
      ST_UP: begin
        if (any_hard || !all_lanes) begin
          state_next = ST_RESET;
        end
      end
      default: begin
        state_next = ST_RESET;
      end
    endcase
  end

  // Reset hold gives lane engines time to clear before re-init
  always @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_RESET;
      hold_reg <= `SECM_RESET_HOLD_CYCLES;
    end else begin
      state_reg <= state_next;
      if (state_next == ST_RESET && state_reg != ST_RESET) begin
        hold_reg <= `SECM_RESET_HOLD_CYCLES;
      end else if (state_reg == ST_RESET && hold_reg != 4'h0) begin
        hold_reg <= hold_reg - 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  // Hard error follows its causes one cycle later and stays high for as long as a cause persists
  always @(posedge clk) begin
    if (rst) begin
      soft_err <= 1'b0;
      hard_err <= 1'b0;
      rx_hard_err <= 1'b0;
      frame_err <= 1'b0;
      init_restart <= 1'b1;
    end else begin
      soft_err <= soft_now;
      hard_err <= (SIMPLEX != 0) ? (tx_hard || (|lock_lost)) : any_hard;
      rx_hard_err <= (SIMPLEX != 0) && rx_hard;
      frame_err <= frame_now;
      init_restart <= (state_next == ST_RESET);
    end
  end

  // Lane and channel status; cleared while restarting
  always @(posedge clk) begin
    if (rst || state_next == ST_RESET) begin
      lane_up <= {LANES{1'b0}};
      channel_up <= 1'b0;
    end else begin
      lane_up <= lane_init_done;
      channel_up <= (state_next == ST_UP);
    end
  end

  // Data is not gated or buffered; valid stays low until fully up
  always @(posedge clk) begin
    if (rst) begin
      rx_data_out <= {DW{1'b0}};
      rx_valid_out <= 1'b0;
    end else begin
      rx_data_out <= rx_data_in;
      rx_valid_out <= rx_valid_in && (state_reg == ST_UP) && all_lanes && (state_next == ST_UP);
    end
  end

endmodule

// >>> testbench/secm_lanes.sv
`timescale 1ns/1ps
// Far lane engines: lanes finish one by one, dly sets prompt or slow
module secm_lanes (
  input wire clk,
  input wire init_restart,
  input wire [7:0] dly,
  output reg [3:0] lane_init_done,
  output reg bond_done
);
  reg [7:0] cnt_reg;
  integer i;
  // Restart wipes progress so a stale done never leaks into a new init
  always @(posedge clk) begin
    cnt_reg <= init_restart ? 8'h00 : cnt_reg + {7'h00, cnt_reg != 8'hff};
    for (i = 0; i < 4; i = i + 1)
      lane_init_done[i] <= !init_restart && cnt_reg > dly + i;
    bond_done <= !init_restart && cnt_reg > dly + 8'h04;
  end
endmodule

// >>> testbench/secm_top_asserts.sv
`timescale 1ns/1ps
// Port-level checker for the error and init monitor
module secm_chk #(parameter LANES = 4, SIMPLEX = 0, TX_ONLY = 0, DW = 16) (
  // Clock and reset
  input wire clk, rst,
  // Causes
  input wire [LANES-1:0] rx_code_invalid, rx_disp_err, tx_buf_err, rx_buf_err, lock_lost, lane_init_done,
  input wire tx_bad_ctrl, rx_unknown_ctrl, ufc_len_bad, bond_done, rx_valid_in,
  // Results
  input wire [DW-1:0] rx_data_in, rx_data_out,
  input wire soft_err, hard_err, frame_err, channel_up, init_restart, rx_valid_out,
  input wire [LANES-1:0] lane_up
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Each flag answers its cause one cycle later
  soft_flag_a: assert property (!TX_ONLY && |(rx_code_invalid | rx_disp_err) |=> soft_err)
    else $error("soft flag missed");
  hard_flag_a: assert property (!SIMPLEX && (|(tx_buf_err | rx_buf_err | lock_lost) || tx_bad_ctrl) |=> hard_err)
    else $error("hard flag missed");
  hard_restart_a: assert property (hard_err |-> init_restart && !channel_up && lane_up == '0)
    else $error("ready kept on hard error");
  frame_flag_a: assert property (channel_up && (rx_unknown_ctrl || ufc_len_bad) ##1 channel_up |-> frame_err)
    else $error("frame flag missed");
  chan_rise_a: assert property ($rose(channel_up) |-> $past(&lane_init_done) && $past(bond_done))
    else $error("channel up early");
  chan_lanes_a: assert property (channel_up |-> &lane_up)
    else $error("channel up without lanes");
  data_pass_a: assert property (rx_valid_in && channel_up ##1 channel_up |-> rx_valid_out && rx_data_out == $past(rx_data_in))
    else $error("data lost");
  reset_clear_a: assert property ($fell(rst) |-> init_restart && !channel_up && lane_up == '0)
    else $error("ready after reset");
  cover property (hard_err);
  cover property (frame_err);
  cover property (channel_up && rx_valid_out);
endmodule
bind secm_top secm_chk #(.LANES(LANES), .SIMPLEX(SIMPLEX), .TX_ONLY(TX_ONLY), .DW(DW)) u_chk (.*);

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst = 1, tx_bad_ctrl = 0, rx_valid_in = 0, bond_done, soft_err, hard_err, rx_hard_err;
  logic frame_err, channel_up, init_restart, rx_valid_out;
  logic [3:0] rx_code_invalid = 0, rx_disp_err = 0, tx_buf_err = 0, rx_buf_err = 0, lock_lost = 0;
  logic [3:0] lane_init_done, lane_up;
  logic [4:0] ev = 0;
  logic [7:0] dly = 8'h03;
  logic [15:0] rx_data_in = 0, rx_data_out;
  wire rx_sof, rx_eof, rx_data_beat, rx_unknown_ctrl, ufc_len_bad;
  int error_cnt = 0, checks = 0;
  assign {ufc_len_bad, rx_unknown_ctrl, rx_data_beat, rx_eof, rx_sof} = ev;
  secm_top u_dut (.*);
  secm_lanes u_lanes (.*);
  initial forever #50 clk = ~clk;
  task step;
    @(posedge clk);
    #1;
  endtask
  task chk(input logic [15:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Offer data all through init; a dead init ends the run
  task wait_up;
    int n;
    rx_valid_in = 1;
    for (n = 0; n < 200 && channel_up !== 1; n++) begin
      step;
      if (channel_up !== 1) chk(rx_valid_out, 0, "data before ready");
    end
    rx_valid_in = 0;
    if (n == 200) begin
      error_cnt++;
      close_out;
    end
    chk(lane_up, 4'hf, "lanes");
  endtask
  task t_data;
    rx_valid_in = 1;
    rx_data_in = 16'h1234;
    step;
    rx_data_in = 16'hbeef;
    chk(rx_data_out, 16'h1234, "data");
    chk(rx_valid_out, 1, "valid");
    step;
    rx_valid_in = 0;
    chk(rx_data_out, 16'hbeef, "data 2");
    chk(rx_valid_out, 1, "valid 2");
    step;
    chk(rx_valid_out, 0, "valid off");
    $display("data done");
  endtask
  // Good frame, empty, nested start, orphan end, unknown char, bad length
  task t_frame;
    logic [5:0] seq [12] = '{6'h01, 6'h04, 6'h02, 6'h01, 6'h22, 6'h01, 6'h04, 6'h21, 6'h06, 6'h22, 6'h28, 6'h30};
    foreach (seq[i]) begin
      ev = seq[i][4:0];
      step;
      chk(frame_err, seq[i][5], "frame");
    end
    ev = 0;
    $display("frame done");
  endtask
  // Two lone errors stay under the bucket limit, a burst does not
  task t_soft;
    rx_code_invalid = 4'h4;
    step;
    rx_code_invalid = 0;
    chk(soft_err, 1, "code");
    rx_disp_err = 4'h1;
    step;
    rx_disp_err = 0;
    chk(soft_err, 1, "disparity");
    repeat (3) step;
    chk({hard_err, channel_up}, 2'h1, "lone soft");
    rx_code_invalid = 4'h8;
    repeat (3) step;
    rx_code_invalid = 0;
    repeat (2) step;
    chk(channel_up, 0, "burst");
    wait_up;
    $display("soft done");
  endtask
  task t_hard;
    for (int k = 0; k < 4; k++) begin
      case (k)
        0: tx_buf_err[k] = 1;
        1: rx_buf_err[k] = 1;
        2: lock_lost[k] = 1;
        default: tx_bad_ctrl = 1;
      endcase
      step;
      {tx_buf_err, rx_buf_err, lock_lost, tx_bad_ctrl} = 0;
      chk({hard_err, init_restart, channel_up, lane_up}, 7'h60, "hard");
      chk(rx_hard_err, 0, "no simplex hard");
      wait_up;
    end
    $display("hard done");
  endtask
  initial begin
    repeat (10) step;
    chk({init_restart, channel_up}, 2'h2, "reset");
    rst = 0;
    wait_up;
    t_data;
    t_frame;
    t_soft;
    dly = 8'h20;
    t_hard;
    close_out;
  end
endmodule
